// ### src/core_reset_defines.svh
// constants for the core reset and option block
// included by the core module and the testbench
`ifndef CORE_RESET_DEFINES_SVH
`define CORE_RESET_DEFINES_SVH
`define IDX_ALT_PTR 12'h0FC
`define IDX_STACK_PTR 12'h0FD
`define IDX_PRI_PTR 12'h0FE
`define IDX_OPTION 12'hFFF
`define IDX_STATUS 12'h0F0
`define IDX_WD_CTRL 12'h0F1
`define ADDR_W 14
`define SP_RESET 8'h6F
`define PC_RESET 15'h0000
`define PC_TRAP 15'h7FFF
`define PC_VECTOR 15'h00FF
`define TRAP_OPCODE 8'h00
`define POR_PRESET 8'hFF
`define WD_WIN_RESET 2'h3
`define CM_RELEASE_TICKS 5'h10
`define OPT_LOW_VOLT_INPUT_COMPAT 7
`define OPT_OSC_MSB 6
`define OPT_OSC_MID 4
`define OPT_OSC_LSB 3
`define OPT_WDOG 2
`define OPT_HALT 1
`endif

// ### src/core_reset_pkg.sv
// types for the core reset and option block
// assumes core_reset_defines.svh on the include path
package core_reset_pkg;
	typedef enum logic [1:0] {
		POR_HOLD = 2'h0,
		EXT_HOLD = 2'h1,
		RUNNING = 2'h3
	} rst_state_t;
endpackage : core_reset_pkg

// ### src/core_reset_and_option_config.sv
// reset sequencer, stack/pc reset state, watchdog arming, option decode
// assumes an APB master on sys_clk and async pins from the board
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "core_reset_defines.svh"
module core_reset_and_option_config import core_reset_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// async pins and detectors
	input wire logic resetPinN,
	input wire logic porDetect,
	input wire logic clockMinOk,
	// same-domain core signals
	input wire logic idleTimerTick,
	input wire logic stackPush,
	input wire logic stackReturn,
	input wire logic interruptTake,
	input wire logic fetchAdvance,
	input wire logic haltRequest,
	input wire logic serialIfEnable,
	input wire logic [7:0] romData,
	input wire logic [7:0] optionByte,
	// apb
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core state
	output logic coreResetN,
	output logic coreRegClear,
	output logic [14:0] program_counter,
	output logic [7:0] fetchByte,
	output logic trapRequest,
	output logic haltActive,
	// option decode
	output logic watchdogEnable,
	output logic haltEnable,
	output logic low_volt_input_compat,
	output logic [2:0] oscSelect,
	// pins
	output logic generalPortsHiZ,
	output logic [7:0] portJOut,
	output logic [7:0] portJOe,
	output logic extIntPullup,
	output logic capturePullup,
	output logic watchdog_output_pin,
	output logic watchdogPinOe,
	output logic watchdogPinPullup
);
	logic [2:0] syncA, syncB, syncC, syncVal;
	logic [2:0] asyncIn;
	rst_state_t rstState;
	logic [7:0] porCount;
	logic [7:0] stack_pointer, primary_ram_pointer, alternate_ram_pointer;
	logic [7:0] optLatch;
	logic [1:0] wdWindow;
	logic cmBit, cmError, clockOkSeen;
	logic [4:0] cmCount;
	logic regWrite, regRead;
	logic pinLow, porLive, clkOk, inReset;

	function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [11:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction : hit

	// three-stage synchronisers; value moves only when stages two and three agree
	assign asyncIn = {clockMinOk, porDetect, resetPinN};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					syncA[gi] <= 1'b0;
					syncB[gi] <= 1'b0;
					syncC[gi] <= 1'b0;
					syncVal[gi] <= 1'b0;
				end else begin
					syncA[gi] <= asyncIn[gi];
					syncB[gi] <= syncA[gi];
					syncC[gi] <= syncB[gi];
					if (syncB[gi] == syncC[gi]) begin
						syncVal[gi] <= syncC[gi];
					end
				end
			end
		end
	endgenerate
	assign pinLow = !syncVal[0];
	assign porLive = syncVal[1];
	assign clkOk = syncVal[2];
	assign inReset = (rstState != RUNNING);

	// reset sequencer: por presets idle count, pin holds while low
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstState <= POR_HOLD;
			porCount <= `POR_PRESET;
		end else if (porLive) begin
			rstState <= POR_HOLD;
			porCount <= `POR_PRESET;
		end else begin
			unique case (rstState)
				POR_HOLD: begin
					if (idleTimerTick) begin
						if (porCount == 8'h00) begin
							rstState <= pinLow ? EXT_HOLD : RUNNING;
						end else begin
							porCount <= porCount - 8'h01;
						end
					end
				end
				EXT_HOLD: begin
					if (!pinLow) begin
						rstState <= RUNNING;
					end
				end
				RUNNING: begin
					if (pinLow) begin
						rstState <= EXT_HOLD;
					end
				end
			endcase
		end
	end

	// registered reset outputs, released on a clock edge
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			coreResetN <= 1'b0;
			coreRegClear <= 1'b1;
		end else begin
			coreResetN <= !inReset && !pinLow && !porLive;
			coreRegClear <= inReset || pinLow || porLive;
		end
	end

	// option byte is a strap, sampled every clock through reset and held once reset ends
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			optLatch <= 8'hFF;
		end else if (inReset) begin
			optLatch <= optionByte;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			watchdogEnable <= 1'b0;
			haltEnable <= 1'b0;
			low_volt_input_compat <= 1'b0;
			oscSelect <= 3'h0;
		end else begin
			watchdogEnable <= !optLatch[`OPT_WDOG];
			haltEnable <= !optLatch[`OPT_HALT];
			low_volt_input_compat <= optLatch[`OPT_LOW_VOLT_INPUT_COMPAT] && serialIfEnable;
			oscSelect <= {optLatch[`OPT_OSC_MSB], optLatch[`OPT_OSC_MID],
				optLatch[`OPT_OSC_LSB]};
		end
	end

	// halt: entry only when permitted, external reset always exits
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			haltActive <= 1'b0;
		end else if (pinLow || inReset) begin
			haltActive <= 1'b0;
		end else if (haltRequest && haltEnable) begin
			haltActive <= 1'b1;
		end
	end

	// program counter
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			program_counter <= `PC_RESET;
		end else if (inReset) begin
			program_counter <= `PC_RESET;
		end else if (interruptTake) begin
			program_counter <= `PC_VECTOR;
		end else if (stackReturn && stack_pointer == `SP_RESET) begin
			program_counter <= `PC_TRAP;
		end else if (fetchAdvance && !haltActive) begin
			program_counter <= program_counter + 15'h0001;
		end
	end

	// the top of program space always reads as the trap opcode
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fetchByte <= `TRAP_OPCODE;
			trapRequest <= 1'b0;
		end else begin
			fetchByte <= (program_counter == `PC_TRAP) ? `TRAP_OPCODE : romData;
			trapRequest <= !inReset && program_counter == `PC_TRAP && fetchAdvance;
		end
	end

	assign regWrite = psel && penable && pready && pwrite;
	assign regRead = psel && !penable;

	// stack pointer: reset value, push down, return up
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stack_pointer <= `SP_RESET;
		end else if (inReset) begin
			stack_pointer <= `SP_RESET;
		end else if (regWrite && hit(paddr, `IDX_STACK_PTR)) begin
			stack_pointer <= pwdata[7:0];
		end else if (stackPush) begin
			stack_pointer <= stack_pointer - 8'h01;
		end else if (stackReturn && stack_pointer != `SP_RESET) begin
			stack_pointer <= stack_pointer + 8'h01;
		end
	end

	// pointers have no reset so a warm reset leaves them alone
	always_ff @(posedge sys_clk) begin
		if (regWrite && hit(paddr, `IDX_PRI_PTR)) begin
			primary_ram_pointer <= pwdata[7:0];
		end
		if (regWrite && hit(paddr, `IDX_ALT_PTR)) begin
			alternate_ram_pointer <= pwdata[7:0];
		end
	end

	// watchdog window: set high by reset, software may narrow it
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wdWindow <= `WD_WIN_RESET;
		end else if (inReset) begin
			wdWindow <= `WD_WIN_RESET;
		end else if (regWrite && hit(paddr, `IDX_WD_CTRL)) begin
			wdWindow <= pwdata[1:0];
		end
	end

	// clock monitor: armed at release, error held until clock good for 16 ticks
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmBit <= 1'b1;
			cmError <= 1'b0;
			clockOkSeen <= 1'b0;
			cmCount <= 5'h00;
		end else if (inReset || !watchdogEnable) begin
			cmBit <= 1'b1;
			cmError <= 1'b0;
			clockOkSeen <= 1'b0;
			cmCount <= 5'h00;
		end else begin
			if (cmBit && !clkOk) begin
				cmError <= 1'b1;
			end
			if (!clkOk) begin
				cmCount <= 5'h00;
				clockOkSeen <= 1'b0;
			end else if (idleTimerTick && cmCount != `CM_RELEASE_TICKS) begin
				cmCount <= cmCount + 5'h01;
			end
			if (clkOk && cmCount == `CM_RELEASE_TICKS) begin
				cmError <= 1'b0;
				clockOkSeen <= 1'b1;
				cmBit <= 1'b0;
			end
		end
	end

	// pin states during and after reset
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			generalPortsHiZ <= 1'b1;
			portJOut <= 8'hFF;
			portJOe <= 8'hFF;
			extIntPullup <= 1'b1;
			capturePullup <= 1'b1;
			watchdog_output_pin <= 1'b1;
			watchdogPinOe <= 1'b0;
			watchdogPinPullup <= 1'b0;
		end else begin
			generalPortsHiZ <= inReset;
			portJOut <= 8'hFF;
			portJOe <= inReset ? 8'hFF : 8'h00;
			extIntPullup <= inReset;
			capturePullup <= inReset;
			watchdog_output_pin <= !cmError;
			watchdogPinOe <= watchdogEnable && cmError;
			watchdogPinPullup <= watchdogEnable;
		end
	end

	// apb slave: no wait states, reads captured in setup
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= regRead;
			pslverr <= 1'b0;
			if (regRead) begin
				prdata <= 32'h0000_0000;
				if (hit(paddr, `IDX_STACK_PTR)) begin
					prdata[7:0] <= stack_pointer;
				end else if (hit(paddr, `IDX_PRI_PTR)) begin
					prdata[7:0] <= primary_ram_pointer;
				end else if (hit(paddr, `IDX_ALT_PTR)) begin
					prdata[7:0] <= alternate_ram_pointer;
				end else if (hit(paddr, `IDX_OPTION)) begin
					prdata[7:0] <= optLatch;
					pslverr <= pwrite;
				end else if (hit(paddr, `IDX_STATUS)) begin
					prdata[5:0] <= {clockOkSeen, cmError, haltActive, pinLow,
						rstState == POR_HOLD, inReset};
				end else if (hit(paddr, `IDX_WD_CTRL)) begin
					prdata[1:0] <= wdWindow;
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	sequence porRelease_s;
		rstState == POR_HOLD ##1 rstState != POR_HOLD;
	endsequence

	pc_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$past(inReset) |-> program_counter == `PC_RESET)
		else $error("pc not zero after reset");
	sp_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$past(inReset) |-> stack_pointer == `SP_RESET)
		else $error("sp not 6F after reset");
	ret_trap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!inReset && !interruptTake && stackReturn && stack_pointer == `SP_RESET
		|=> program_counter == `PC_TRAP)
		else $error("return at 6F not to 7FFF");
	trap_fetch_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		program_counter == `PC_TRAP |=> fetchByte == `TRAP_OPCODE)
		else $error("7FFF fetch not 00");
	int_vector_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!inReset && interruptTake |=> program_counter == `PC_VECTOR)
		else $error("interrupt not to 00FF");
	port_j_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		inReset |=> portJOe == 8'hFF && portJOut == 8'hFF)
		else $error("port J not high in reset");
	halt_exit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		pinLow |=> !haltActive)
		else $error("halt kept through reset");
	por_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		porRelease_s |-> $past(porCount) == 8'h00)
		else $error("por released early");
	wd_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		inReset |=> !cmError)
		else $error("monitor active in reset");
	cm_pin_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		cmError && watchdogEnable |=> watchdogPinOe && !watchdog_output_pin)
		else $error("monitor error not on pin");
	opt_wd_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		optLatch[`OPT_WDOG] |=> !watchdogEnable ##1 !watchdogPinPullup)
		else $error("watchdog enable wrong polarity");
	rst_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		pinLow |=> !coreResetN)
		else $error("pin low without core reset");
endmodule : core_reset_and_option_config

// ### verification/reset_supervisor.sv
// external reset circuit model that drives the reset pin low on request
// assumes trigger and holdCycles come from the bench on sys_clk
`timescale 1ns/1ps
module reset_supervisor #(
	parameter int MIN_LOW = 8
) (
	// control
	input wire logic sys_clk,
	input wire logic trigger,
	input wire logic [7:0] holdCycles,
	// pin
	output logic resetPinN
);
	int remaining = 0;
	// single driver: the pin settles high at the first edge, long before resetn lifts
	// a short request is stretched: a shorter low pulse would not be a valid reset
	always @(posedge sys_clk) begin
		if (trigger) begin
			remaining <= (int'(holdCycles) < MIN_LOW) ? MIN_LOW : int'(holdCycles);
		end else if (remaining > 0) begin
			remaining <= remaining - 1;
		end
		resetPinN <= !(trigger || remaining > 1);
	end
endmodule : reset_supervisor

// ### verification/tb_core_reset_and_option_config.sv
// self-checking bench for the reset and option block
// assumes the design files and the reset supervisor model are compiled first
`timescale 1ns/1ps
`include "core_reset_defines.svh"
module tb_core_reset_and_option_config;
	localparam logic [13:0] A_ALT = {`IDX_ALT_PTR, 2'b00};
	localparam logic [13:0] A_SP = {`IDX_STACK_PTR, 2'b00};
	localparam logic [13:0] A_PRI = {`IDX_PRI_PTR, 2'b00};
	localparam logic [13:0] A_OPT = {`IDX_OPTION, 2'b00};
	localparam logic [13:0] A_WIN = {`IDX_WD_CTRL, 2'b00};
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic porDetect = 1'b0, clockMinOk = 1'b0, idleTimerTick = 1'b0, trigger = 1'b0;
	logic stackPush = 1'b0, stackReturn = 1'b0, interruptTake = 1'b0, fetchAdvance = 1'b0;
	logic haltRequest = 1'b0, serialIfEnable = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] romData = 8'hA5, optionByte = 8'h00, holdCycles = 8'h00, opt, r1, r2;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic resetPinN, pready, pslverr, coreResetN, coreRegClear, trapRequest, haltActive;
	logic watchdogEnable, haltEnable, low_volt_input_compat, generalPortsHiZ, extIntPullup;
	logic capturePullup, watchdog_output_pin, watchdogPinOe, watchdogPinPullup;
	logic [14:0] program_counter;
	logic [7:0] fetchByte, portJOut, portJOe;
	logic [2:0] oscSelect;
	logic [33:0] expQ[$];
	logic [33:0] e;
	int failures = 0, n_checks = 0, n, seed;

	reset_supervisor i_reset_supervisor (.sys_clk, .trigger, .holdCycles, .resetPinN);
	core_reset_and_option_config i_core_reset_and_option_config (.sys_clk, .resetn,
		.resetPinN, .porDetect, .clockMinOk, .idleTimerTick, .stackPush, .stackReturn,
		.interruptTake, .fetchAdvance, .haltRequest, .serialIfEnable, .romData, .optionByte,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .coreResetN,
		.coreRegClear, .program_counter, .fetchByte, .trapRequest, .haltActive,
		.watchdogEnable, .haltEnable, .low_volt_input_compat, .oscSelect, .generalPortsHiZ,
		.portJOut, .portJOe, .extIntPullup, .capturePullup, .watchdog_output_pin,
		.watchdogPinOe, .watchdogPinPullup);

	always #4 sys_clk = ~sys_clk;
	// tick every other cycle keeps the power-on hold near 512 cycles
	always @(posedge sys_clk) idleTimerTick <= ~idleTimerTick;

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task summarize();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task done(input string s);
		$display("end of test %s", s);
	endtask : done

	// read: d is the expected data; write: d is sent
	task apb(input logic wr, input logic [13:0] a, input logic [31:0] d, input logic err);
		expQ.push_back({!wr, err, d});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wr ? d : 32'h00000000;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1);
		check(n, 1, "apb wait states");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task waitRst(input logic lvl, input int lim);
		n = 0;
		while (coreResetN !== lvl && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		check(coreResetN, lvl, "core reset level");
	endtask : waitRst

	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (expQ.size() == 0) begin
				check(1'b0, 1'b1, "unexpected answer");
			end else begin
				e = expQ.pop_front();
				if (e[33]) check(prdata, e[31:0], "read data");
				check(pslverr, e[32], "slave error");
			end
		end
	end

	initial begin
		// the whole run is near 1200 cycles
		repeat (20000) @(posedge sys_clk);
		failures++;
		summarize();
	end

	initial begin
		seed = $urandom(54);
		// bit 7 forced so the serial-enable gate on the low-voltage inputs can be seen
		opt = (8'($urandom) & 8'hF9) | 8'h80;
		optionByte = opt;
		repeat (10) @(posedge sys_clk);
		check(coreResetN, 1'b0, "in reset");
		check(coreRegClear, 1'b1, "reg clear");
		check(program_counter, 15'h0000, "pc in reset");
		check({portJOut, portJOe}, 16'hFFFF, "port j");
		check({generalPortsHiZ, extIntPullup, capturePullup}, 3'h7, "pins");
		check(watchdogPinOe, 1'b0, "watchdog idle");
		resetn <= 1'b1;
		waitRst(1'b1, 2000);
		check(n >= 510 && n <= 530, 1'b1, "power-on length");
		check({coreRegClear, portJOe, generalPortsHiZ}, 10'h000, "after reset");
		repeat (2) @(posedge sys_clk);
		check({watchdog_output_pin, watchdogPinOe}, 2'b01, "monitor error");
		clockMinOk <= 1'b1;
		n = 0;
		while (watchdog_output_pin !== 1'b1 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		check(n >= 32 && n <= 72, 1'b1, "monitor release");
		check({watchdogEnable, watchdogPinPullup, haltEnable}, 3'h7, "options");
		check({low_volt_input_compat, oscSelect}, {opt[7], opt[6], opt[4], opt[3]}, "osc");
		serialIfEnable <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check(low_volt_input_compat, 1'b0, "low-volt gated");
		serialIfEnable <= 1'b1;
		done("power-on");
		apb(1'b0, A_SP, 32'h0000006F, 1'b0);
		apb(1'b0, A_WIN, 32'h00000003, 1'b0);
		apb(1'b0, A_OPT, {24'h000000, opt}, 1'b0);
		apb(1'b1, A_OPT, 32'h0000005A, 1'b1);
		apb(1'b0, A_OPT, {24'h000000, opt}, 1'b0);
		apb(1'b0, 14'h0100, 32'h00000000, 1'b1);
		done("registers");
		stackPush <= 1'b1;
		@(posedge sys_clk);
		stackPush <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, A_SP, 32'h0000006E, 1'b0);
		apb(1'b1, A_SP, 32'h0000006F, 1'b0);
		stackReturn <= 1'b1;
		@(posedge sys_clk);
		stackReturn <= 1'b0;
		fetchAdvance <= 1'b1;
		@(posedge sys_clk);
		check(program_counter, 15'h7FFF, "return at top");
		fetchAdvance <= 1'b0;
		n = 0;
		while (trapRequest !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			n++;
		end
		check({trapRequest, fetchByte}, 9'h100, "trap fetch");
		interruptTake <= 1'b1;
		@(posedge sys_clk);
		interruptTake <= 1'b0;
		@(posedge sys_clk);
		check(program_counter, 15'h00FF, "vector");
		done("core");
		r1 = 8'($urandom);
		r2 = 8'($urandom);
		apb(1'b1, A_ALT, {24'h000000, r1}, 1'b0);
		apb(1'b1, A_PRI, {24'h000000, r2}, 1'b0);
		haltRequest <= 1'b1;
		@(posedge sys_clk);
		haltRequest <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check(haltActive, 1'b1, "halt entered");
		apb(1'b1, A_SP, 32'h00000040, 1'b0);
		apb(1'b1, A_WIN, 32'h00000001, 1'b0);
		// watchdog and halt turned off for the next reset to pick up
		optionByte <= opt | 8'h06;
		holdCycles <= 8'($urandom_range(40, 4));
		trigger <= 1'b1;
		@(posedge sys_clk);
		trigger <= 1'b0;
		waitRst(1'b0, 60);
		repeat (2) @(posedge sys_clk);
		check({haltActive, portJOe}, 9'h0FF, "halt exit");
		waitRst(1'b1, 200);
		apb(1'b0, A_ALT, {24'h000000, r1}, 1'b0);
		apb(1'b0, A_PRI, {24'h000000, r2}, 1'b0);
		apb(1'b0, A_SP, 32'h0000006F, 1'b0);
		apb(1'b0, A_WIN, 32'h00000003, 1'b0);
		check(program_counter, 15'h0000, "pc after pin reset");
		check({watchdogEnable, watchdogPinPullup, haltEnable}, 3'h0, "options off");
		haltRequest <= 1'b1;
		@(posedge sys_clk);
		haltRequest <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check(haltActive, 1'b0, "halt refused");
		done("pin reset");
		apb(1'b1, A_SP, 32'h00000040, 1'b0);
		porDetect <= 1'b1;
		waitRst(1'b0, 20);
		repeat (4) @(posedge sys_clk);
		check(coreRegClear, 1'b1, "por clear");
		porDetect <= 1'b0;
		waitRst(1'b1, 2000);
		check(n >= 510 && n <= 530, 1'b1, "por restart length");
		apb(1'b0, A_SP, 32'h0000006F, 1'b0);
		done("power-on detector");
		summarize();
	end
endmodule : tb_core_reset_and_option_config
